// ### lfw_pkg.sv
// Constants, types and register map of the wake-up pattern decoder
package lfw_pkg;
    // Register indices (8-bit registers, one per address)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CDR = 4'h1;
    localparam logic [3:0] ADDR_FRAME = 4'h2;
    localparam logic [3:0] ADDR_RSSI = 4'h3;
    localparam logic [3:0] ADDR_HDR = 4'h4;
    localparam logic [3:0] ADDR_IDL = 4'h5;
    localparam logic [3:0] ADDR_IDH = 4'h6;
    localparam logic [3:0] ADDR_IMR = 4'h7;
    localparam logic [3:0] ADDR_FLAGS = 4'h8;
    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_BURST_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    // Control-and-data register fields
    localparam int CDR_RAW_BIT = 0;
    localparam int CDR_RST_BIT = 6;
    localparam int CDR_CAP_BIT = 7;
    // Flag and mask positions
    localparam int FLG_WAKE = 0;
    localparam int FLG_BUF = 1;
    localparam int FLG_EOD = 2;
    localparam int FLG_RSSI = 3;
    localparam logic [7:0] RST_REG = 8'h00;
    // Wake-mode field encodings
    localparam logic [1:0] WM_GAP = 2'h0;
    localparam logic [1:0] WM_HDR = 2'h1;
    localparam logic [1:0] WM_HDR_ID = 2'h2;
    localparam logic [1:0] WM_TRANS = 2'h3;
    // Timing: core clock, slow RC period, Manchester bit period
    localparam int CLK_PERIOD_NS = 8;
    localparam int SRC_PERIOD_NS = 11111;
    localparam int SRC_DIV = SRC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BIT_PERIOD_NS = 256000;
    localparam int BIT_CYC_DOC = BIT_PERIOD_NS / CLK_PERIOD_NS;
    // Windows in slow RC periods
    localparam logic [7:0] SG_MIN = 8'd10;
    localparam logic [7:0] SG_MAX = 8'd200;
    localparam logic [7:0] SB_MIN = 8'd48;
    localparam logic [7:0] SBG_MAX = 8'd100;
    localparam logic [7:0] GAP_TIMEOUT = 8'd200;
    localparam int HDR_BITS = 7;
    localparam int ID_BITS = 16;
    localparam int FRAME_BITS = 8;

    typedef enum logic [3:0] {
        ST_LISTEN, ST_PRE, ST_GAP, ST_FBURST, ST_SBURST, ST_SBGAP,
        ST_HDR, ST_ID, ST_DATA, ST_TRANS
    } lfw_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lfw_bus_req_t;

    typedef struct packed {
        logic wake;
        logic buf_full;
        logic eod;
    } lfw_irq_t;
endpackage

// ### lfw_decoder.sv
// Wake-up pattern decoder: preamble timing, Manchester decode, flags
//
// How it works
// - Flag register upper four bits read zero
// - Strength flag set on value load, write-one clears
// - End-of-data flag on error, end, or timeout
// - End-of-data cleared by vector or write-one
// - Buffer-full set per frame, vector or write clears
// - Wake flag set on wake, vector or write clears
// - Burst bit plus mode field pick six modes
// - Manchester, rising edge is one, 3.90625 kb/s
// - Wake windows counted in slow RC periods
// - Mode 1 wakes on first burst rising edge
// - Start gap between 10 and 200 periods
// - Each received byte raises buffer interrupt
// - Missing start, header, id, gap or disable: standby
// - Mode 2 syncs on falling edge, wakes after header
// - Mode 3 needs header then 16-bit identifier
// - Burst preamble: start burst, gap, then burst
// - Modes 4 and 5 wake after header or id
// - Transparent mode leaves standby to software reset
// - Mode field 00 gap, 01 header, 10 id, 11 transparent
// - Interrupt needs mask bit and global enable
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
module lfw_decoder
    import lfw_pkg::*;
#(
    parameter int BIT_CYC = BIT_CYC_DOC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire lfw_pkg::lfw_bus_req_t bus_req,
    output logic [7:0] rd_data,
    input wire logic env_in,
    input wire logic preamble_in,
    input wire logic [6:0] agc_strength,
    input wire logic global_int_en,
    input wire lfw_pkg::lfw_irq_t vector_ack,
    output lfw_pkg::lfw_irq_t irq,
    output logic raw_demod_output
);
    import lfw_pkg::*;

    localparam logic [15:0] BIT_3Q = 16'((BIT_CYC * 3) / 4);
    localparam logic [15:0] BIT_3H = 16'((BIT_CYC * 3) / 2);
    localparam logic [15:0] BIT_1 = 16'(BIT_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic env_s1_ff, env_s2_ff, env_d_ff;
    logic pre_s1_ff, pre_s2_ff;
    logic [6:0] agc_s1_ff, agc_s2_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            env_s1_ff <= 1'b0;
            env_s2_ff <= 1'b0;
            env_d_ff <= 1'b0;
            pre_s1_ff <= 1'b0;
            pre_s2_ff <= 1'b0;
            agc_s1_ff <= 7'h00;
            agc_s2_ff <= 7'h00;
        end else begin
            env_s1_ff <= env_in;
            env_s2_ff <= env_s1_ff;
            env_d_ff <= env_s2_ff;
            pre_s1_ff <= preamble_in;
            pre_s2_ff <= pre_s1_ff;
            agc_s1_ff <= agc_strength;
            agc_s2_ff <= agc_s1_ff;
        end
    end

    logic rise, fall, edge_any;
    assign rise = env_s2_ff & ~env_d_ff;
    assign fall = ~env_s2_ff & env_d_ff;
    assign edge_any = rise | fall;

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    logic [7:0] ctrl_ff, imr_ff, hdr_cmp_ff, idl_ff, idh_ff, rssi_ff, frame_ff;
    logic cap_req_ff, fe_rst_ff;
    logic [3:0] flags_ff;
    logic wr_ctrl, wr_cdr, wr_flags;

    assign wr_ctrl = bus_req.wr && bus_req.addr == ADDR_CTRL;
    assign wr_cdr = bus_req.wr && bus_req.addr == ADDR_CDR;
    assign wr_flags = bus_req.wr && bus_req.addr == ADDR_FLAGS;

    logic en;
    logic burst_sel;
    logic [1:0] mode;
    assign en = ctrl_ff[CTRL_EN_BIT];
    assign burst_sel = ctrl_ff[CTRL_BURST_BIT];
    assign mode = ctrl_ff[CTRL_MODE_LSB +: 2];

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= RST_REG;
            imr_ff <= RST_REG;
            hdr_cmp_ff <= RST_REG;
            idl_ff <= RST_REG;
            idh_ff <= RST_REG;
            fe_rst_ff <= 1'b0;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                ADDR_CTRL: ctrl_ff <= bus_req.wdata;
                ADDR_IMR: imr_ff <= {5'h00, bus_req.wdata[2:0]};
                ADDR_HDR: hdr_cmp_ff <= {1'b0, bus_req.wdata[6:0]};
                ADDR_IDL: idl_ff <= bus_req.wdata;
                ADDR_IDH: idh_ff <= bus_req.wdata;
                ADDR_CDR: fe_rst_ff <= bus_req.wdata[CDR_RST_BIT];
                default: ;
            endcase
        end
    end

    // Strength capture: one shot, only while the receiver runs
    logic rssi_load;
    assign rssi_load = cap_req_ff & en;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_req_ff <= 1'b0;
            rssi_ff <= RST_REG;
        end else begin
            if (wr_cdr && bus_req.wdata[CDR_CAP_BIT]) begin
                cap_req_ff <= 1'b1;
            end else if (rssi_load) begin
                cap_req_ff <= 1'b0;
            end
            if (rssi_load) begin
                rssi_ff <= {1'b0, agc_s2_ff};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slow RC period tick and edge-to-edge period count
    logic [10:0] div_ff;
    logic [7:0] tick_cnt_ff;
    logic [15:0] bit_tmr_ff;
    logic tick;
    assign tick = div_ff == 11'(SRC_DIV - 1);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= 11'h000;
            tick_cnt_ff <= 8'h00;
        end else begin
            div_ff <= tick ? 11'h000 : div_ff + 11'h001;
            if (edge_any) begin
                tick_cnt_ff <= 8'h00;
            end else if (tick && tick_cnt_ff != 8'hff) begin
                tick_cnt_ff <= tick_cnt_ff + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pattern state machine
    lfw_state_t state_ff, nxt_state;
    logic [15:0] shift_ff;
    logic [4:0] bit_cnt_ff;
    logic mid_edge, bit_lost, mbit;
    logic wake_set, frame_set, eod_set, sync_now;
    logic in_manch;

    assign in_manch = state_ff == ST_HDR || state_ff == ST_ID || state_ff == ST_DATA;
    assign mid_edge = in_manch && edge_any && bit_tmr_ff >= BIT_3Q;
    assign mbit = rise;
    assign bit_lost = in_manch && bit_tmr_ff >= BIT_3H;

    logic [4:0] nxt_cnt;
    logic [15:0] nxt_shift;
    assign nxt_cnt = bit_cnt_ff + 5'h01;
    assign nxt_shift = {shift_ff[14:0], mbit};

    function automatic logic in_win(input logic [7:0] t, input logic [7:0] lo, input logic [7:0] hi);
        return t > lo && t < hi;
    endfunction

    always_comb begin
        nxt_state = state_ff;
        wake_set = 1'b0;
        frame_set = 1'b0;
        eod_set = 1'b0;
        sync_now = 1'b0;
        case (state_ff)
            ST_LISTEN: begin
                if (en && pre_s2_ff) begin
                    nxt_state = mode == WM_TRANS ? ST_TRANS : ST_PRE;
                end
            end
            ST_PRE: begin
                if (!pre_s2_ff && !env_s2_ff && tick_cnt_ff >= GAP_TIMEOUT) begin
                    nxt_state = ST_LISTEN;
                end else if (burst_sel && mode != WM_GAP) begin
                    // start burst after the burst preamble
                    if (fall && in_win(tick_cnt_ff, SB_MIN, SG_MAX)) begin
                        nxt_state = ST_SBGAP;
                    end
                end else if (fall) begin
                    nxt_state = ST_GAP;
                end
            end
            ST_GAP: begin
                if (rise) begin
                    if (!in_win(tick_cnt_ff, SG_MIN, SG_MAX)) begin
                        nxt_state = ST_LISTEN;
                    end else if (mode == WM_GAP) begin
                        // sync and wake on rising edge
                        nxt_state = ST_DATA;
                        wake_set = 1'b1;
                        sync_now = 1'b1;
                    end else begin
                        nxt_state = ST_FBURST;
                    end
                end else if (tick_cnt_ff >= SG_MAX) begin
                    nxt_state = ST_LISTEN;
                end
            end
            ST_SBGAP: begin
                if (rise) begin
                    nxt_state = in_win(tick_cnt_ff, SG_MIN, SBG_MAX) ? ST_FBURST : ST_LISTEN;
                end else if (tick_cnt_ff >= SBG_MAX) begin
                    nxt_state = ST_LISTEN;
                end
            end
            ST_FBURST: begin
                // sync on falling edge of the first burst
                if (fall) begin
                    if (bit_tmr_ff > BIT_1 && tick_cnt_ff < SG_MAX) begin
                        nxt_state = ST_HDR;
                        sync_now = 1'b1;
                    end else begin
                        nxt_state = ST_LISTEN;
                    end
                end else if (tick_cnt_ff >= SG_MAX) begin
                    nxt_state = ST_LISTEN;
                end
            end
            ST_HDR: begin
                if (bit_lost) begin
                    nxt_state = ST_LISTEN;
                    eod_set = 1'b1;
                end else if (mid_edge && nxt_cnt == 5'(HDR_BITS)) begin
                    if (nxt_shift[6:0] != hdr_cmp_ff[6:0]) begin
                        nxt_state = ST_LISTEN;
                    end else if (mode == WM_HDR) begin
                        nxt_state = ST_DATA;
                        wake_set = 1'b1;
                    end else begin
                        nxt_state = ST_ID;
                    end
                end
            end
            ST_ID: begin
                if (bit_lost) begin
                    nxt_state = ST_LISTEN;
                    eod_set = 1'b1;
                end else if (mid_edge && nxt_cnt == 5'(ID_BITS)) begin
                    if (nxt_shift != {idh_ff, idl_ff}) begin
                        nxt_state = ST_LISTEN;
                    end else begin
                        nxt_state = ST_DATA;
                        wake_set = 1'b1;
                    end
                end
            end
            ST_DATA: begin
                // end of stream, bit error or timeout
                if (bit_lost) begin
                    nxt_state = ST_LISTEN;
                    eod_set = 1'b1;
                end else if (mid_edge && nxt_cnt == 5'(FRAME_BITS)) begin
                    frame_set = 1'b1;
                end
            end
            ST_TRANS: begin
                if (fe_rst_ff) begin
                    nxt_state = ST_LISTEN;
                end
            end
            default: nxt_state = ST_LISTEN;
        endcase
        if (!en && state_ff != ST_TRANS) begin
            nxt_state = ST_LISTEN;
        end
        // Switching to transparent mid-frame hands data to software
        if (en && mode == WM_TRANS && state_ff != ST_LISTEN && state_ff != ST_TRANS) begin
            nxt_state = ST_TRANS;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_LISTEN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Bit timer restarts on sync, on mid-bit edges in a frame and on any edge outside one; boundary edges are skipped
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_tmr_ff <= 16'h0000;
        end else if (sync_now || mid_edge || (!in_manch && edge_any)) begin
            bit_tmr_ff <= 16'h0000;
        end else if (bit_tmr_ff != 16'hffff) begin
            bit_tmr_ff <= bit_tmr_ff + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_ff <= 16'h0000;
            bit_cnt_ff <= 5'h00;
        end else if (sync_now || nxt_state != state_ff) begin
            bit_cnt_ff <= 5'h00;
        end else if (mid_edge) begin
            shift_ff <= nxt_shift;
            bit_cnt_ff <= frame_set ? 5'h00 : nxt_cnt;
        end
    end

    // each byte lands in the frame buffer
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_ff <= RST_REG;
        end else if (frame_set) begin
            frame_ff <= nxt_shift[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags: a set in the same cycle as a clear wins
    logic [3:0] clr, set, nxt_flags;
    always_comb begin
        // zeros and reserved bits do nothing
        clr = wr_flags ? bus_req.wdata[3:0] : 4'h0;
        clr[FLG_EOD] = clr[FLG_EOD] | vector_ack.eod;
        clr[FLG_BUF] = clr[FLG_BUF] | vector_ack.buf_full;
        clr[FLG_WAKE] = clr[FLG_WAKE] | vector_ack.wake;
        set = {rssi_load, eod_set, frame_set, wake_set};
        nxt_flags = (flags_ff & ~clr) | set;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_ff <= 4'h0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // mask and global enable gate each request
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= '0;
        end else begin
            irq.wake <= nxt_flags[FLG_WAKE] & imr_ff[FLG_WAKE] & global_int_en;
            irq.buf_full <= nxt_flags[FLG_BUF] & imr_ff[FLG_BUF] & global_int_en;
            irq.eod <= nxt_flags[FLG_EOD] & imr_ff[FLG_EOD] & global_int_en;
        end
    end

    // raw data follows the envelope once a frame is under way
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            raw_demod_output <= 1'b0;
        end else begin
            raw_demod_output <= state_ff != ST_LISTEN && state_ff != ST_PRE && env_s2_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port; unmapped addresses read zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= 8'h00;
        end else if (!bus_req.rd) begin
            rd_data <= 8'h00;
        end else begin
            case (bus_req.addr)
                ADDR_CTRL: rd_data <= ctrl_ff;
                ADDR_CDR: rd_data <= {cap_req_ff, fe_rst_ff, 5'h00, raw_demod_output};
                ADDR_FRAME: rd_data <= frame_ff;
                ADDR_RSSI: rd_data <= rssi_ff;
                ADDR_HDR: rd_data <= hdr_cmp_ff;
                ADDR_IDL: rd_data <= idl_ff;
                ADDR_IDH: rd_data <= idh_ff;
                ADDR_IMR: rd_data <= imr_ff;
                ADDR_FLAGS: rd_data <= {4'h0, flags_ff};
                default: rd_data <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_flags_reserved: assert property (@(posedge core_clk) disable iff (!reset_n)
        bus_req.rd && bus_req.addr == ADDR_FLAGS |=> rd_data[7:4] == 4'h0 && rd_data[3:0] == $past(flags_ff))
        else $error("flag register read mismatch");
    chk_rssi_capture: assert property (@(posedge core_clk) disable iff (!reset_n)
        cap_req_ff && en |=> flags_ff[FLG_RSSI] && rssi_ff[6:0] == $past(agc_s2_ff) && !cap_req_ff)
        else $error("strength capture not flagged");
    chk_eod_raise: assert property (@(posedge core_clk) disable iff (!reset_n)
        bit_lost && state_ff == ST_DATA |=> flags_ff[FLG_EOD] && state_ff == ST_LISTEN)
        else $error("end of data not flagged");
    chk_eod_vector: assert property (@(posedge core_clk) disable iff (!reset_n)
        vector_ack.eod && !eod_set |=> !flags_ff[FLG_EOD])
        else $error("end of data flag not cleared by vector");
    chk_frame_load: assert property (@(posedge core_clk) disable iff (!reset_n)
        frame_set |=> flags_ff[FLG_BUF] && frame_ff == $past(nxt_shift[7:0]))
        else $error("frame not loaded");
    chk_zero_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_flags && bus_req.wdata[3:0] == 4'h0 && vector_ack == '0 |=> flags_ff == ($past(flags_ff) | $past(set)))
        else $error("zero write changed a flag");
    chk_gap_window: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_ff == ST_GAP && rise && (tick_cnt_ff <= SG_MIN || tick_cnt_ff >= SG_MAX) |=> state_ff == ST_LISTEN)
        else $error("start gap outside window accepted");
    chk_irq_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
        irq.wake |-> $past(imr_ff[FLG_WAKE]) && $past(global_int_en) && flags_ff[FLG_WAKE])
        else $error("wake request without mask");
    chk_trans_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_ff == ST_TRANS && !fe_rst_ff |=> state_ff == ST_TRANS)
        else $error("transparent mode left without reset");
    chk_disable_drop: assert property (@(posedge core_clk) disable iff (!reset_n)
        !en && in_manch |=> state_ff == ST_LISTEN)
        else $error("disable did not return to standby");
endmodule

// ### lfw_tx_model.sv
// Behavioural model of the remote low-frequency transmitter
module lfw_tx_model
    import lfw_pkg::*;
#(
    parameter int BIT_CYC = 64
) (
    input wire logic core_clk,
    output logic env_in,
    output logic preamble_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        env_in = 1'b0;
        preamble_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Carrier level held for a whole number of core cycles
    task automatic hold(input logic lvl, input int cyc);
        @(posedge core_clk);
        env_in <= lvl;
        repeat (cyc - 1) @(posedge core_clk);
    endtask

    task automatic start(input int ticks);
        @(posedge core_clk);
        preamble_in <= 1'b1;
        env_in <= 1'b1;
        repeat (200) @(posedge core_clk);
        preamble_in <= 1'b0;
        env_in <= 1'b0;
        repeat (ticks * SRC_DIV - 1) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Manchester, rising mid edge is one
    // Wide enough for header and identifier sent back to back
    task automatic manch(input logic [31:0] data, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            hold(~data[i], BIT_CYC / 2);
            hold(data[i], BIT_CYC / 2);
        end
        // Carrier off after the frame, so no stale level lingers
        hold(1'b0, 4 * BIT_CYC);
    endtask
endmodule

// ### lfw_decoder_tb.sv
// Self-checking bench for the wake-up pattern decoder
module lfw_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lfw_pkg::*;
    localparam int BC = 64;
    logic core_clk, reset_n, global_int_en, env_in, preamble_in, raw_demod_output;
    lfw_bus_req_t bus_req;
    lfw_irq_t vector_ack, irq;
    logic [7:0] rd_data, v;
    logic [6:0] agc_strength;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    lfw_decoder #(.BIT_CYC(BC)) uut (.core_clk(core_clk), .reset_n(reset_n), .bus_req(bus_req),
        .rd_data(rd_data), .env_in(env_in), .preamble_in(preamble_in), .agc_strength(agc_strength),
        .global_int_en(global_int_en), .vector_ack(vector_ack), .irq(irq), .raw_demod_output(raw_demod_output));
    lfw_tx_model #(.BIT_CYC(BC)) tx (.core_clk(core_clk), .env_in(env_in), .preamble_in(preamble_in));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 v = rd_data;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        rd(a);
        chk($sformatf("register %h", a), v, exp);
    endtask

    task automatic ack(input lfw_irq_t m);
        @(posedge core_clk);
        vector_ack <= m;
        @(posedge core_clk);
        vector_ack <= '0;
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Four framed runs of about 18k cycles each fit below this
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        global_int_en = 1'b1;
        vector_ack = '0;
        agc_strength = 7'h5a;
        bus_req = '0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        rchk(ADDR_FLAGS, RST_REG);
        wr(ADDR_IMR, 8'h07);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_CDR, 8'h80);
        repeat (6) @(posedge core_clk);
        rchk(ADDR_RSSI, 8'h5a);
        rchk(ADDR_FLAGS, 8'h08);
        wr(ADDR_FLAGS, 8'hf0);
        rchk(ADDR_FLAGS, 8'h08);
        wr(ADDR_FLAGS, 8'h08);
        rchk(ADDR_FLAGS, 8'h00);
        // Mode 00: gap then rising edge wakes, one byte follows
        tx.start(12);
        tx.hold(1'b1, BC / 2);
        chk("wake irq", {7'h00, irq.wake}, 8'h01);
        tx.manch(32'h00a5, 8);
        rchk(ADDR_FRAME, 8'ha5);
        rchk(ADDR_FLAGS, 8'h07);
        chk("all irqs", {5'h00, irq}, 8'h07);
        global_int_en <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("masked irq", {5'h00, irq}, 8'h00);
        global_int_en <= 1'b1;
        wr(ADDR_FLAGS, 8'hf2);
        rchk(ADDR_FLAGS, 8'h05);
        ack('{wake: 1'b1, buf_full: 1'b0, eod: 1'b0});
        rchk(ADDR_FLAGS, 8'h04);
        ack('{wake: 1'b0, buf_full: 1'b0, eod: 1'b1});
        rchk(ADDR_FLAGS, 8'h00);
        // Mode 01: wrong header falls back silently, right one wakes
        wr(ADDR_HDR, 8'h35);
        wr(ADDR_CTRL, 8'h05);
        for (int k = 0; k < 2; k++) begin
            tx.start(12);
            // first burst longer than one bit
            tx.hold(1'b1, 200);
            tx.hold(1'b0, BC / 2);
            tx.manch(k ? 32'h0035 : 32'h0036, 7);
            rchk(ADDR_FLAGS, k ? 8'h05 : 8'h00);
        end
        // Mode 10: header and identifier back to back, wake at the last id bit
        wr(ADDR_FLAGS, 8'h0f);
        wr(ADDR_IDH, 8'hc3);
        wr(ADDR_IDL, 8'ha6);
        wr(ADDR_CTRL, 8'h09);
        tx.start(12);
        tx.hold(1'b1, 200);
        tx.hold(1'b0, BC / 2);
        tx.manch({9'h000, 7'h35, 16'hc3a6}, 23);
        rchk(ADDR_FLAGS, 8'h05);
        // Mode 11: raw envelope out, held until the front-end reset
        wr(ADDR_FLAGS, 8'h0f);
        wr(ADDR_CTRL, 8'h0d);
        tx.start(1);
        tx.hold(1'b1, 8);
        chk("raw out", {7'h00, raw_demod_output}, 8'h01);
        rchk(ADDR_FLAGS, 8'h00);
        wr(ADDR_CDR, 8'h40);
        repeat (3) @(posedge core_clk);
        chk("raw after reset", {7'h00, raw_demod_output}, 8'h00);
        wr(ADDR_CDR, 8'h00);
        give_verdict();
    end
endmodule
